// File: port_pkg.sv
package port_pkg;
   // one 16-pin port; register byte addresses on classic wishbone
   localparam int PIN_COUNT = 16;
   localparam int SEL_WIDTH = 8;
   localparam int ROUTE_PINS = 256;
   localparam logic [7:0] ADDR_ANALOG = 8'h00;
   localparam logic [7:0] ADDR_DIR = 8'h04;
   localparam logic [7:0] ADDR_INPUT = 8'h08;
   localparam logic [7:0] ADDR_LATCH = 8'h0c;
   localparam logic [7:0] ADDR_OPEN_DRAIN = 8'h10;
   localparam logic [7:0] ADDR_PULL_UP = 8'h14;
   localparam logic [7:0] ADDR_PULL_DOWN = 8'h18;
   localparam logic [7:0] ADDR_CN_CONTROL = 8'h1c;
   localparam logic [7:0] ADDR_CN_ENABLE_A = 8'h20;
   localparam logic [7:0] ADDR_CN_STATUS = 8'h24;
   localparam logic [7:0] ADDR_CN_ENABLE_B = 8'h28;
   localparam logic [7:0] ADDR_CN_FLAG = 8'h2c;
   localparam logic [7:0] ADDR_ROUTE_CAP3_TMR3 = 8'h30;
   localparam logic [7:0] ADDR_ROUTE_CAP4_TMR4 = 8'h34;
   localparam logic [15:0] ANALOG_RESET = 16'hffff;
   localparam logic [15:0] DIR_RESET = 16'hffff;
   localparam logic [15:0] ZERO_RESET = 16'h0000;
   // change-notice control: bit 15 enables, bit 11 selects edge-flag mode
   localparam int CN_ON_BIT = 15;
   localparam int CN_EDGE_BIT = 11;
   localparam int CAP_SEL_LSB = 8;
   localparam int TMR_SEL_LSB = 0;
endpackage

// File: route_if.sv
`timescale 1ns/10ps
interface route_if;
   logic [port_pkg::ROUTE_PINS-1:0] pins;
   logic [7:0] cap3_sel;
   logic [7:0] tmr3_sel;
   logic [7:0] cap4_sel;
   logic [7:0] tmr4_sel;
   logic cap3;
   logic tmr3;
   logic cap4;
   logic tmr4;
   modport owner (output pins, output cap3_sel, output tmr3_sel, output cap4_sel,
                  output tmr4_sel, input cap3, input tmr3, input cap4, input tmr4);
   modport router (input pins, input cap3_sel, input tmr3_sel, input cap4_sel,
                   input tmr4_sel, output cap3, output tmr3, output cap4, output tmr4);
endinterface

// File: input_router.sv
`timescale 1ns/10ps
module input_router
   import port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   route_if.router rt
);
   logic [3:0] route_reg;
   logic [3:0] route_next;

   function automatic logic pick(input logic [ROUTE_PINS-1:0] pins, input logic [7:0] sel);
      pick = pins[sel];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registered mux output keeps the switch itself the only glitch
   always_comb
   begin
      // RULE9: selector picks pin
      route_next[0] = pick(rt.pins, rt.cap3_sel);
      route_next[1] = pick(rt.pins, rt.tmr3_sel);
      route_next[2] = pick(rt.pins, rt.cap4_sel);
      route_next[3] = pick(rt.pins, rt.tmr4_sel);
   end

   // RULE13: next-cycle effect
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         route_reg <= 4'h0;
      else
         route_reg <= route_next;
   end

   assign rt.cap3 = route_reg[0];
   assign rt.tmr3 = route_reg[1];
   assign rt.cap4 = route_reg[2];
   assign rt.tmr4 = route_reg[3];
endmodule

// File: port_pins.sv
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
// How it works
// RULE1: per-pin open-drain bit makes driver only pull low.
// RULE2: software sets analog select and direction for analog use.
// RULE3: software clears analog select before digital use.
// RULE4: analog select register resets to all ones.
// RULE5: input register reads zero for analog pins.
// RULE6: output pin with analog select still drives its digital level.
// RULE7: software waits one instruction after write before reading port.
// RULE8: port owns analog, direction, input, latch, drain, pulls, change-notice registers.
// RULE9: each routed peripheral input follows the pin named by its selector.
// RULE10: fifth selector register: capture 3 high byte, timer 3 low byte.
// RULE11: sixth selector register: capture 4 high byte, timer 4 low byte.
// RULE12: digital output pins drive the latch; input pins turn driver off.
// RULE13: selector writes reach routed inputs by next clock.
module port_pins
   import port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic [PIN_COUNT-1:0] pin_i,
   output logic [PIN_COUNT-1:0] pin_o,
   output logic [PIN_COUNT-1:0] pin_oe_o,
   output logic [PIN_COUNT-1:0] pull_up_o,
   output logic [PIN_COUNT-1:0] pull_down_o,
   output logic [PIN_COUNT-1:0] analog_level_o,
   input wire logic [ROUTE_PINS-1:0] remappable_pin_i,
   output logic capture3_o,
   output logic timer3_clock_o,
   output logic capture4_o,
   output logic timer4_clock_o
);
   logic [15:0] analog_select_reg, analog_select_next;
   logic [15:0] pin_direction_reg, pin_direction_next;
   logic [15:0] output_latch_reg, output_latch_next;
   logic [15:0] open_drain_enable_reg, open_drain_enable_next;
   logic [15:0] pull_up_enable_reg, pull_up_enable_next;
   logic [15:0] pull_down_enable_reg, pull_down_enable_next;
   logic [15:0] change_notice_control_reg, change_notice_control_next;
   logic [15:0] change_notice_enable_a_reg, change_notice_enable_a_next;
   logic [15:0] change_notice_enable_b_reg, change_notice_enable_b_next;
   logic [15:0] change_notice_status_reg, change_notice_status_next;
   logic [15:0] change_notice_flag_reg, change_notice_flag_next;
   logic [15:0] route_cap3_tmr3_reg, route_cap3_tmr3_next;
   logic [15:0] route_cap4_tmr4_reg, route_cap4_tmr4_next;
   logic [15:0] sync1_reg, sync2_reg, prev_reg;
   logic [15:0] pin_input_value;
   logic [15:0] cn_event;
   logic [31:0] rdata_reg, rdata_next;
   logic ack_reg, ack_next;
   logic wr_hit;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   route_if rt();

   input_router u_router
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rt(rt)
   );

   ////////////////////////////////////////////////////////////////////////
   // pin input synchroniser and change notice
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_reg <= ZERO_RESET;
         sync2_reg <= ZERO_RESET;
         prev_reg <= ZERO_RESET;
      end
      else
      begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
         // compare against the masked value, so a pin raises no change notice while it stays analog
         prev_reg <= pin_input_value;
      end
   end

   // RULE5: analog pins read zero
   assign pin_input_value = sync2_reg & ~analog_select_reg;

   // mismatch mode flags any change; edge mode uses enable_a for rise, enable_b for fall
   always_comb
   begin
      if (!change_notice_control_reg[CN_ON_BIT])
         cn_event = ZERO_RESET;
      else if (change_notice_control_reg[CN_EDGE_BIT])
         cn_event = (change_notice_enable_a_reg & pin_input_value & ~prev_reg)
                  | (change_notice_enable_b_reg & ~pin_input_value & prev_reg);
      else
         cn_event = (change_notice_enable_a_reg | change_notice_enable_b_reg)
                  & (pin_input_value ^ prev_reg);
   end

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after strobe, dropped the next cycle
   assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

   always_comb
   begin
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      analog_select_next = analog_select_reg;
      pin_direction_next = pin_direction_reg;
      output_latch_next = output_latch_reg;
      open_drain_enable_next = open_drain_enable_reg;
      pull_up_enable_next = pull_up_enable_reg;
      pull_down_enable_next = pull_down_enable_reg;
      change_notice_control_next = change_notice_control_reg;
      change_notice_enable_a_next = change_notice_enable_a_reg;
      change_notice_enable_b_next = change_notice_enable_b_reg;
      change_notice_status_next = change_notice_status_reg | cn_event;
      change_notice_flag_next = change_notice_flag_reg;
      route_cap3_tmr3_next = route_cap3_tmr3_reg;
      route_cap4_tmr4_next = route_cap4_tmr4_reg;
      // RULE8: per-port register set
      if (wr_hit)
      begin
         case (wb_adr_i)
            ADDR_ANALOG: analog_select_next = merge(analog_select_reg, wb_dat_i, wb_sel_i);
            ADDR_DIR: pin_direction_next = merge(pin_direction_reg, wb_dat_i, wb_sel_i);
            ADDR_LATCH: output_latch_next = merge(output_latch_reg, wb_dat_i, wb_sel_i);
            ADDR_INPUT: output_latch_next = merge(output_latch_reg, wb_dat_i, wb_sel_i);
            ADDR_OPEN_DRAIN:
               open_drain_enable_next = merge(open_drain_enable_reg, wb_dat_i, wb_sel_i);
            ADDR_PULL_UP: pull_up_enable_next = merge(pull_up_enable_reg, wb_dat_i, wb_sel_i);
            ADDR_PULL_DOWN:
               pull_down_enable_next = merge(pull_down_enable_reg, wb_dat_i, wb_sel_i);
            ADDR_CN_CONTROL:
               change_notice_control_next = merge(change_notice_control_reg, wb_dat_i, wb_sel_i);
            ADDR_CN_ENABLE_A:
               change_notice_enable_a_next = merge(change_notice_enable_a_reg, wb_dat_i,
                                                   wb_sel_i);
            ADDR_CN_ENABLE_B:
               change_notice_enable_b_next = merge(change_notice_enable_b_reg, wb_dat_i,
                                                   wb_sel_i);
            ADDR_CN_STATUS:
               change_notice_status_next = merge(change_notice_status_reg, wb_dat_i, wb_sel_i)
                                         | cn_event;
            ADDR_CN_FLAG:
               change_notice_flag_next = merge(change_notice_flag_reg, wb_dat_i, wb_sel_i);
            // RULE10: capture3 and timer3 selectors
            ADDR_ROUTE_CAP3_TMR3:
               route_cap3_tmr3_next = merge(route_cap3_tmr3_reg, wb_dat_i, wb_sel_i);
            // RULE11: capture4 and timer4 selectors
            ADDR_ROUTE_CAP4_TMR4:
               route_cap4_tmr4_next = merge(route_cap4_tmr4_reg, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
      // hardware set wins over a same-cycle software clear
      change_notice_flag_next = change_notice_flag_next | cn_event;
   end

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg)
      begin
         case (wb_adr_i)
            ADDR_ANALOG: rdata_next[15:0] = analog_select_reg;
            ADDR_DIR: rdata_next[15:0] = pin_direction_reg;
            ADDR_INPUT: rdata_next[15:0] = pin_input_value;
            ADDR_LATCH: rdata_next[15:0] = output_latch_reg;
            ADDR_OPEN_DRAIN: rdata_next[15:0] = open_drain_enable_reg;
            ADDR_PULL_UP: rdata_next[15:0] = pull_up_enable_reg;
            ADDR_PULL_DOWN: rdata_next[15:0] = pull_down_enable_reg;
            ADDR_CN_CONTROL: rdata_next[15:0] = change_notice_control_reg;
            ADDR_CN_ENABLE_A: rdata_next[15:0] = change_notice_enable_a_reg;
            ADDR_CN_ENABLE_B: rdata_next[15:0] = change_notice_enable_b_reg;
            ADDR_CN_STATUS: rdata_next[15:0] = change_notice_status_reg;
            ADDR_CN_FLAG: rdata_next[15:0] = change_notice_flag_reg;
            ADDR_ROUTE_CAP3_TMR3: rdata_next[15:0] = route_cap3_tmr3_reg;
            ADDR_ROUTE_CAP4_TMR4: rdata_next[15:0] = route_cap4_tmr4_reg;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         // RULE4: analog after reset
         analog_select_reg <= ANALOG_RESET;
         pin_direction_reg <= DIR_RESET;
         output_latch_reg <= ZERO_RESET;
         open_drain_enable_reg <= ZERO_RESET;
         pull_up_enable_reg <= ZERO_RESET;
         pull_down_enable_reg <= ZERO_RESET;
         change_notice_control_reg <= ZERO_RESET;
         change_notice_enable_a_reg <= ZERO_RESET;
         change_notice_enable_b_reg <= ZERO_RESET;
         change_notice_status_reg <= ZERO_RESET;
         change_notice_flag_reg <= ZERO_RESET;
         route_cap3_tmr3_reg <= ZERO_RESET;
         route_cap4_tmr4_reg <= ZERO_RESET;
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
      end
      else
      begin
         analog_select_reg <= analog_select_next;
         pin_direction_reg <= pin_direction_next;
         output_latch_reg <= output_latch_next;
         open_drain_enable_reg <= open_drain_enable_next;
         pull_up_enable_reg <= pull_up_enable_next;
         pull_down_enable_reg <= pull_down_enable_next;
         change_notice_control_reg <= change_notice_control_next;
         change_notice_enable_a_reg <= change_notice_enable_a_next;
         change_notice_enable_b_reg <= change_notice_enable_b_next;
         change_notice_status_reg <= change_notice_status_next;
         change_notice_flag_reg <= change_notice_flag_next;
         route_cap3_tmr3_reg <= route_cap3_tmr3_next;
         route_cap4_tmr4_reg <= route_cap4_tmr4_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // pin drivers; analog select deliberately does not gate the driver
   // RULE12: latch drives outputs
   // RULE6: analog keeps drive
   // RULE1: open drain pulls low
   assign pin_o = output_latch_reg & ~open_drain_enable_reg;
   assign pin_oe_o = ~pin_direction_reg & ~(open_drain_enable_reg & output_latch_reg);
   assign pull_up_o = pull_up_enable_reg;
   assign pull_down_o = pull_down_enable_reg;
   assign analog_level_o = analog_select_reg;

   // RULE9: selectors feed router
   assign rt.pins = remappable_pin_i;
   assign rt.cap3_sel = route_cap3_tmr3_reg[CAP_SEL_LSB +: SEL_WIDTH];
   assign rt.tmr3_sel = route_cap3_tmr3_reg[TMR_SEL_LSB +: SEL_WIDTH];
   assign rt.cap4_sel = route_cap4_tmr4_reg[CAP_SEL_LSB +: SEL_WIDTH];
   assign rt.tmr4_sel = route_cap4_tmr4_reg[TMR_SEL_LSB +: SEL_WIDTH];
   assign capture3_o = rt.cap3;
   assign timer3_clock_o = rt.tmr3;
   assign capture4_o = rt.cap4;
   assign timer4_clock_o = rt.tmr4;
endmodule

// File: pad_model.sv
`timescale 1ns/10ps
module pad_model
   import port_pkg::*;
(
   input wire logic [PIN_COUNT-1:0] drive_i,
   input wire logic [PIN_COUNT-1:0] enable_i,
   input wire logic [PIN_COUNT-1:0] up_i,
   input wire logic [PIN_COUNT-1:0] down_i,
   input wire logic [PIN_COUNT-1:0] float_i,
   output logic [PIN_COUNT-1:0] level_o
);
   // pad level resolution
   // a floating pad takes the bench hint, never a held old value
   assign level_o = (enable_i & drive_i) | (~enable_i & up_i)
                  | (~enable_i & ~up_i & ~down_i & float_i);
endmodule

// File: port_pins_asserts.sv
`timescale 1ns/10ps
module port_pins_asserts
   import port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [PIN_COUNT-1:0] pin_o,
   input wire logic [PIN_COUNT-1:0] pin_oe_o,
   input wire logic [PIN_COUNT-1:0] analog_level_o,
   input wire logic [ROUTE_PINS-1:0] remappable_pin_i,
   input wire logic capture3_o,
   input wire logic timer3_clock_o,
   input wire logic capture4_o,
   input wire logic timer4_clock_o
);
   logic take;
   logic [15:0] r5_reg, r6_reg, od_reg, r5_next, r6_next, od_next;
   ////////////////////////////////////////////////////////////////
   function automatic logic [15:0] merge(input logic [15:0] old, input logic hit,
                                         input logic [3:0] s, input logic [31:0] d);
      merge = old;
      if (hit && s[0]) merge[7:0] = d[7:0];
      if (hit && s[1]) merge[15:8] = d[15:8];
   endfunction
   // shadow copies of written registers, updated at the edge the request is taken
   always_comb
   begin
      take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
      r5_next = merge(r5_reg, take && wb_adr_i == ADDR_ROUTE_CAP3_TMR3, wb_sel_i, wb_dat_i);
      r6_next = merge(r6_reg, take && wb_adr_i == ADDR_ROUTE_CAP4_TMR4, wb_sel_i, wb_dat_i);
      od_next = merge(od_reg, take && wb_adr_i == ADDR_OPEN_DRAIN, wb_sel_i, wb_dat_i);
      if (rst_i)
      begin
         r5_next = 16'h0000;
         r6_next = 16'h0000;
         od_next = 16'h0000;
      end
   end
   always_ff @(posedge clk_i)
   begin
      r5_reg <= r5_next;
      r6_reg <= r6_next;
      od_reg <= od_next;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence read_input_ack;
      wb_ack_o && !wb_we_i && wb_adr_i == ADDR_INPUT;
   endsequence
   a_ack_follows_req: assert property (req_taken |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_no_stray_ack: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_reset_analog_mode: assert property (@(posedge clk_i) disable iff (1'b0)
      $fell(rst_i) |-> analog_level_o == ANALOG_RESET && pin_oe_o == 16'h0000)
      else $error("reset state of pads wrong");
   a_input_analog_zero: assert property (read_input_ack |->
      (wb_dat_o[15:0] & analog_level_o) == 16'h0000)
      else $error("analog pin read nonzero");
   a_drain_never_high: assert property ((pin_oe_o & pin_o & od_reg) == 16'h0000)
      else $error("open-drain pin driven high");
   a_route_cap3: assert property ($past(!rst_i) |->
      capture3_o == $past(remappable_pin_i[r5_reg[15:8]]))
      else $error("capture 3 route wrong");
   a_route_tmr3: assert property ($past(!rst_i) |->
      timer3_clock_o == $past(remappable_pin_i[r5_reg[7:0]]))
      else $error("timer 3 route wrong");
   a_route_cap4: assert property ($past(!rst_i) |->
      capture4_o == $past(remappable_pin_i[r6_reg[15:8]]))
      else $error("capture 4 route wrong");
   a_route_tmr4: assert property ($past(!rst_i) |->
      timer4_clock_o == $past(remappable_pin_i[r6_reg[7:0]]))
      else $error("timer 4 route wrong");
endmodule
bind port_pins port_pins_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pin_o(pin_o),
   .pin_oe_o(pin_oe_o), .analog_level_o(analog_level_o), .remappable_pin_i(remappable_pin_i),
   .capture3_o(capture3_o), .timer3_clock_o(timer3_clock_o), .capture4_o(capture4_o),
   .timer4_clock_o(timer4_clock_o));

// File: test_port_pins_with_input_remap.sv
`timescale 1ns/10ps
module test_port_pins_with_input_remap;
   import port_pkg::*;
   logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic capture3_o, timer3_clock_o, capture4_o, timer4_clock_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [15:0] pin_i, pin_o, pin_oe_o, pull_up_o, pull_down_o, analog_level_o, ext;
   logic [255:0] rp;
   int bad_count = 0;
   int samples_checked = 0;
   port_pins u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
      .analog_level_o(analog_level_o), .remappable_pin_i(rp), .capture3_o(capture3_o),
      .timer3_clock_o(timer3_clock_o), .capture4_o(capture4_o), .timer4_clock_o(timer4_clock_o));
   pad_model u_pads (.drive_i(pin_o), .enable_i(pin_oe_o), .up_i(pull_up_o),
      .down_i(pull_down_o), .float_i(ext), .level_o(pin_i));
   always #2.5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////
   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask
   // request held until ack is sampled high at a rising edge; data taken at that edge
   task xfer(input logic [7:0] a, input logic we, input logic [3:0] s, input logic [15:0] d);
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i <= we;
      wb_sel_i <= s;
      wb_dat_i <= {16'h0000, d};
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      // ack ends this wait; if ack never comes, only the watchdog ends it
      do
         @(posedge clk_i);
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      xfer(a, 1'b1, 4'h3, d);
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      xfer(a, 1'b0, 4'h3, 16'h0000);
      check(q, {16'h0000, e});
   endtask
   task test_done;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   task t_reset;
      @(negedge clk_i);
      check(analog_level_o, ANALOG_RESET);
      check(pin_oe_o, 16'h0000);
      rd(ADDR_ANALOG, ANALOG_RESET);
      rd(ADDR_DIR, DIR_RESET);
      rd(ADDR_ROUTE_CAP3_TMR3, ZERO_RESET);
      rd(ADDR_ROUTE_CAP4_TMR4, ZERO_RESET);
      rd(8'h3c, 16'h0000);
      $display("reset test done");
   endtask
   task t_digital;
      wr(ADDR_ANALOG, 16'h0000);
      wr(ADDR_LATCH, 16'ha5c3);
      wr(ADDR_DIR, 16'hff00);
      @(negedge clk_i);
      check(pin_oe_o, 16'h00ff);
      check(pin_o, 16'ha5c3);
      repeat (4) @(posedge clk_i);
      rd(ADDR_INPUT, 16'h3cc3);
      wr(ADDR_ANALOG, 16'h0f0f);
      @(negedge clk_i);
      check(pin_oe_o, 16'h00ff);
      repeat (4) @(posedge clk_i);
      rd(ADDR_INPUT, 16'h3cc3 & ~16'h0f0f);
      wr(ADDR_DIR, 16'hffff);
      @(negedge clk_i);
      check(pin_oe_o, 16'h0000);
      repeat (4) @(posedge clk_i);
      rd(ADDR_INPUT, ext & ~16'h0f0f);
      $display("digital test done");
   endtask
   task t_open_drain;
      wr(ADDR_ANALOG, 16'h0000);
      wr(ADDR_DIR, 16'h0000);
      wr(ADDR_LATCH, 16'h0ff0);
      wr(ADDR_OPEN_DRAIN, 16'hff00);
      wr(ADDR_PULL_UP, 16'h0300);
      wr(ADDR_PULL_DOWN, 16'h0c00);
      @(negedge clk_i);
      check(pin_oe_o, 16'hf0ff);
      check(pin_o, 16'h00f0);
      check({pull_up_o, pull_down_o}, 32'h0300_0c00);
      repeat (4) @(posedge clk_i);
      rd(ADDR_INPUT, 16'h03f0);
      wr(ADDR_OPEN_DRAIN, 16'h0000);
      $display("open drain test done");
   endtask
   task t_route;
      logic [7:0] s;
      logic [7:0] sels [4] = '{8'h00, 8'hff, 8'h05, 8'h80};
      for (int i = 0; i < 4; i++)
      begin
         s = sels[i];
         wr(ADDR_ROUTE_CAP3_TMR3, {s, ~s});
         wr(ADDR_ROUTE_CAP4_TMR4, {s ^ 8'h5a, s + 8'h01});
         rd(ADDR_ROUTE_CAP3_TMR3, {s, ~s});
         rd(ADDR_ROUTE_CAP4_TMR4, {s ^ 8'h5a, s + 8'h01});
         rp <= ~rp;
         @(posedge clk_i);
         @(negedge clk_i);
         check({capture3_o, timer3_clock_o}, {rp[s], rp[~s]});
         check({capture4_o, timer4_clock_o}, {rp[s ^ 8'h5a], rp[s + 8'h01]});
      end
      xfer(ADDR_ROUTE_CAP3_TMR3, 1'b1, 4'h1, 16'h7733);
      rd(ADDR_ROUTE_CAP3_TMR3, 16'h8033);
      $display("route test done");
   endtask
   // pins are driven from the latch here: direction 0, open drain off, analog off
   task t_notice;
      wr(ADDR_CN_ENABLE_A, 16'h0001);
      wr(ADDR_CN_CONTROL, 16'h8000);
      wr(ADDR_LATCH, 16'h0ff1);
      repeat (4) @(posedge clk_i);
      rd(ADDR_CN_STATUS, 16'h0001);
      rd(ADDR_CN_FLAG, 16'h0001);
      wr(ADDR_CN_FLAG, 16'h0000);
      rd(ADDR_CN_FLAG, 16'h0000);
      // edge mode: enable_a watches rising edges only
      wr(ADDR_CN_CONTROL, 16'h8800);
      wr(ADDR_LATCH, 16'h0ff0);
      repeat (4) @(posedge clk_i);
      rd(ADDR_CN_FLAG, 16'h0000);
      wr(ADDR_LATCH, 16'h0ff1);
      repeat (4) @(posedge clk_i);
      rd(ADDR_CN_FLAG, 16'h0001);
      $display("change notice test done");
   endtask
   // a second reset in mid-run must bring every pad back to analog input
   task t_reset_again;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      rd(ADDR_CN_FLAG, 16'h0000);
      rd(ADDR_LATCH, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      ext = 16'h3c00;
      rp = {8{32'h96e1_3c5a}};
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_digital;
      t_open_drain;
      t_route;
      t_notice;
      t_reset_again;
      test_done;
   end
   // the whole run needs well under 1000 cycles
   initial
   begin
      #50000;
      bad_count++;
      test_done;
   end
endmodule
